// >>> design/dac_double_buffer_update.sv
`timescale 1ns/10ps
module dac_double_buffer_update
  import dac_update_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH*CODE_W-1:0] channel_analog_out,
  output logic [NUM_CH-1:0] channel_out_en,
  output logic [NUM_CH-1:0] channel_pulldown
);
  logic [NUM_CH-1:0] sync_r;
  logic [NUM_CH-1:0] clear_r;
  logic [NUM_CH-1:0] power_r;
  logic [CODE_W-1:0] clrv_r [NUM_CH];
  logic load_r;
  logic soft_rst_r;
  logic [31:0] prdata_nxt;
  logic [NUM_CH*CODE_W-1:0] out_nxt;
  logic [NUM_CH-1:0] pend_vec;
  logic [CODE_W-1:0] latch_vec [NUM_CH];
  logic [NUM_CH-1:0] code_hit;
  logic [NUM_CH-1:0] clrv_hit;

  wire access = psel && penable;
  wire wr_acc = access && pwrite;
  wire hit_config = paddr == OFS_CONFIG;
  wire hit_sync = paddr == OFS_SYNC;
  wire hit_clear = paddr == OFS_CLEAR;
  wire hit_power = paddr == OFS_POWER;
  wire hit_reset = paddr == OFS_RESET;
  wire hit_pend = paddr == OFS_PEND;
  wire any_hit = (|code_hit) || (|clrv_hit) || hit_config || hit_sync ||
    hit_clear || hit_power || hit_reset || hit_pend;
  wire load_req = wr_acc && hit_config && pwdata[LOAD_BIT];
  wire soft_req = wr_acc && hit_reset &&
    (pwdata[15:0] == SOFT_RESET_CODE);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      dac_chan_if cif();
      assign code_hit[g] = paddr == OFS_CODE0 + ADDR_W'(4 * g);
      assign clrv_hit[g] = paddr == OFS_CLRV0 + ADDR_W'(4 * g);
      assign cif.wr_code = wr_acc && code_hit[g] && !soft_rst_r;
      assign cif.load_evt = load_r;
      assign cif.sync_sel = sync_r[g];
      assign cif.clear_on = clear_r[g];
      assign cif.soft_rst = soft_rst_r;
      assign cif.wdata = pwdata[CODE_W-1:0];
      assign cif.clr_val = clrv_r[g];
      assign latch_vec[g] = cif.latch_val;
      assign pend_vec[g] = cif.pending;
      assign out_nxt[g*CODE_W +: CODE_W] = cif.out_val;
      dac_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .ch(cif.chan)
      );
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clrv_r[g] <= CLRV_RST;
        end else if (soft_rst_r) begin
          clrv_r[g] <= CLRV_RST;
        end else if (wr_acc && clrv_hit[g]) begin
          clrv_r[g] <= pwdata[CODE_W-1:0];
        end
      end
    end
  endgenerate

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (code_hit[i]) begin
        prdata_nxt[CODE_W-1:0] = latch_vec[i];
      end
      if (clrv_hit[i]) begin
        prdata_nxt[CODE_W-1:0] = clrv_r[i];
      end
    end
    if (hit_sync) begin
      prdata_nxt[NUM_CH-1:0] = sync_r;
    end
    if (hit_clear) begin
      prdata_nxt[NUM_CH-1:0] = clear_r;
    end
    if (hit_power) begin
      prdata_nxt[POWER_DAC_LSB +: NUM_CH] = power_r;
    end
    if (hit_pend) begin
      prdata_nxt[NUM_CH-1:0] = pend_vec;
    end
  end

  // Control registers; load bit is held only as a one-cycle load_r pulse and reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= SYNC_RST;
      clear_r <= CLEAR_RST;
      power_r <= POWER_RST;
      load_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else if (soft_rst_r) begin
      sync_r <= SYNC_RST;
      clear_r <= CLEAR_RST;
      power_r <= POWER_RST;
      load_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else begin
      load_r <= load_req;
      soft_rst_r <= soft_req;
      if (wr_acc && hit_sync) begin
        sync_r <= pwdata[NUM_CH-1:0];
      end
      if (wr_acc && hit_clear) begin
        clear_r <= pwdata[NUM_CH-1:0];
      end
      if (wr_acc && hit_power) begin
        power_r <= pwdata[POWER_DAC_LSB +: NUM_CH];
      end
    end
  end

  // Bus answer and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      channel_analog_out <= '0;
      channel_out_en <= '0;
      channel_pulldown <= '1;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !any_hit;
      prdata <= (psel && !penable && !pwrite) ? prdata_nxt : 32'h0000_0000;
      channel_analog_out <= out_nxt;
      channel_out_en <= power_r;
      channel_pulldown <= ~power_r;
    end
  end
endmodule

// >>> pkg/dac_update_pkg.sv
package dac_update_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 10;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CODE0 = 8'h00;
  localparam logic [7:0] OFS_CLRV0 = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  localparam logic [7:0] OFS_SYNC = 8'h24;
  localparam logic [7:0] OFS_CLEAR = 8'h28;
  localparam logic [7:0] OFS_POWER = 8'h2C;
  localparam logic [7:0] OFS_RESET = 8'h30;
  localparam logic [7:0] OFS_PEND = 8'h34;
  // Field positions and values
  localparam int LOAD_BIT = 11;
  localparam int POWER_DAC_LSB = 0;
  localparam logic [15:0] SOFT_RESET_CODE = 16'h6600;
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam logic [CODE_W-1:0] CLRV_RST = 10'h000;
  localparam logic [NUM_CH-1:0] SYNC_RST = 4'h0;
  localparam logic [NUM_CH-1:0] CLEAR_RST = 4'h0;
  localparam logic [NUM_CH-1:0] POWER_RST = 4'h0;
endpackage

// >>> pkg/dac_chan_if.sv
`timescale 1ns/10ps
interface dac_chan_if;
  import dac_update_pkg::*;
  logic wr_code;
  logic load_evt;
  logic sync_sel;
  logic clear_on;
  logic soft_rst;
  logic [CODE_W-1:0] wdata;
  logic [CODE_W-1:0] clr_val;
  logic [CODE_W-1:0] latch_val;
  logic [CODE_W-1:0] out_val;
  logic pending;
  modport ctrl (output wr_code, load_evt, sync_sel, clear_on, soft_rst,
    wdata, clr_val, input latch_val, out_val, pending);
  modport chan (input wr_code, load_evt, sync_sel, clear_on, soft_rst,
    wdata, clr_val, output latch_val, out_val, pending);
endinterface

// >>> design/dac_channel.sv
`timescale 1ns/10ps
module dac_channel
  import dac_update_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dac_chan_if.chan ch
);
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] latch_r;
  logic pend_r;
  wire take_load = ch.load_evt && ch.sync_sel && pend_r;
  wire async_wr = ch.wr_code && !ch.sync_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r <= CODE_RST;
      latch_r <= CODE_RST;
      pend_r <= 1'b0;
    end else if (ch.soft_rst) begin
      code_r <= CODE_RST;
      latch_r <= CODE_RST;
      pend_r <= 1'b0;
    end else begin
      if (ch.wr_code) begin
        code_r <= ch.wdata;
      end
      if (async_wr) begin
        latch_r <= ch.wdata;
      end else if (take_load) begin
        latch_r <= code_r;
      end
      if (ch.wr_code && ch.sync_sel) begin
        pend_r <= 1'b1;
      end else if (take_load) begin
        pend_r <= 1'b0;
      end
    end
  end

  assign ch.latch_val = latch_r;
  assign ch.pending = pend_r;
  assign ch.out_val = ch.clear_on ? ch.clr_val : latch_r;
endmodule

// >>> bench/dac_update_monitor.sv
`timescale 1ns/10ps
module dac_update_monitor
  import dac_update_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH*CODE_W-1:0] channel_analog_out,
  input wire logic [NUM_CH-1:0] channel_out_en,
  input wire logic [NUM_CH-1:0] channel_pulldown
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  wire wr = pready && pwrite;
  property p_pdn; channel_pulldown == ~channel_out_en; endproperty
  a_pdn: assert property (p_pdn)
    else $error("pulldown not inverse of enable");
  property p_rst; $rose(presetn) |-> channel_analog_out == 0
    && channel_out_en == 0; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not default after reset");
  property p_ld0; rd && paddr == OFS_CONFIG |-> !prdata[LOAD_BIT];
  endproperty
  a_ld0: assert property (p_ld0)
    else $error("load trigger reads one");
  property p_code; rd && paddr < OFS_CLRV0 |-> prdata[31:CODE_W] == 0;
  endproperty
  a_code: assert property (p_code)
    else $error("code read upper bits set");
  property p_out; $changed(channel_analog_out) |-> $past(wr)
    || $past(wr, 2) || $past(wr, 3); endproperty
  a_out: assert property (p_out)
    else $error("output changed without a write");
  property p_en; $changed(channel_out_en) |-> $past(wr && paddr ==
    OFS_POWER, 2) || $past(wr && paddr == OFS_RESET, 3); endproperty
  a_en: assert property (p_en)
    else $error("buffer enable changed without cause");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready not a single access pulse");
  property p_err; rd && pslverr |-> prdata == 0; endproperty
  a_err: assert property (p_err)
    else $error("refused read data not zero");
endmodule

// >>> bench/apb_host.sv
`timescale 1ns/10ps
module apb_host
  import dac_update_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// >>> bench/dac_double_buffer_update_tb.sv
`timescale 1ns/10ps
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module dac_double_buffer_update_tb;
  import dac_update_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] channel_analog_out;
  logic [3:0] channel_out_en, channel_pulldown, syn, clr, pwr, pend;
  logic [9:0] lat[4], cod[4], clv[4];
  int bad_count, n_checks, seed, k;
  dac_double_buffer_update dut(.*);
  apb_host host(.*);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task mreset;
    lat = '{default: CODE_RST};
    cod = '{default: CODE_RST};
    clv = '{default: CLRV_RST};
    {syn, clr, pwr, pend} = {SYNC_RST, CLEAR_RST, POWER_RST, 4'h0};
  endtask
  task chk_all;
    for (int i = 0; i < 4; i++)
      `CHK("out", clr[i] ? clv[i] : lat[i], channel_analog_out[i*10+:10])
    `CHK("en", pwr, channel_out_en)
    `CHK("pd", ~pwr, channel_pulldown)
  endtask
  task r(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'h0, a, 32'h0, rd, er);
    `CHK("rd", e, rd)
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rd, er);
    if (a < OFS_CLRV0) begin
      if (syn[a[3:2]]) pend[a[3:2]] = 1'h1;
      else lat[a[3:2]] = d[9:0];
      cod[a[3:2]] = d[9:0];
    end else if (a < OFS_CONFIG) clv[a[3:2]] = d[9:0];
    else if (a == OFS_CONFIG && d[LOAD_BIT]) begin
      for (int i = 0; i < 4; i++) if (pend[i] && syn[i]) begin
        lat[i] = cod[i];
        pend[i] = 1'h0;
      end
    end else if (a == OFS_SYNC) syn = d[3:0];
    else if (a == OFS_CLEAR) clr = d[3:0];
    else if (a == OFS_POWER) pwr = d[3:0];
    else if (a == OFS_RESET && d[15:0] == SOFT_RESET_CODE) mreset;
    repeat (4) @(posedge pclk);
    chk_all;
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {seed, presetn, bad_count, n_checks} = {32'h9E7C, 1'h0, 64'h0};
    mreset;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    repeat (25000) @(posedge pclk);
    chk_all;
    r(OFS_POWER, 32'h0);
    w(OFS_RESET, 32'h6600);
    repeat (25000) @(posedge pclk);
    w(OFS_POWER, $random(seed));
    for (k = 0; k < 8; k++) begin
      if (k == 4) w(OFS_SYNC, 32'h5);
      w(8'(4 * (k % 4)), $random(seed));
      r(8'(4 * (k % 4)), {22'h0, lat[k%4]});
    end
    r(OFS_PEND, {28'h0, pend});
    w(OFS_CONFIG, 32'h800);
    r(OFS_CONFIG, 32'h0);
    r(OFS_PEND, 32'h0);
    for (k = 0; k < 4; k++) w(8'(16 + 4 * k), $random(seed));
    w(OFS_CLEAR, 32'hF);
    w(OFS_CODE0 + 8'h8, $random(seed));
    w(OFS_CONFIG, 32'h800);
    w(OFS_CLEAR, 32'h0);
    w(OFS_RESET, 32'h6601);
    r(8'h3C, 32'h0);
    `CHK("err", 1'h1, er)
    w(OFS_RESET, 32'h6600);
    repeat (25000) @(posedge pclk);
    r(OFS_CODE0 + 8'h8, 32'h0);
    tally_and_finish;
  end
endmodule
bind dac_double_buffer_update dac_update_monitor u_mon(.*);
